// File: rtl/clc_pkg.sv
/*
 * Shared constants and types for the logic cell cluster: cell configuration
 * word layout, cluster control lines, register map and bus carriers.
 * Assumes a single 40 MHz system clock and an APB master in the same domain.
 */
`default_nettype none

package clc_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int CLC_NCELL = 10;
	localparam int CLC_NDATA = 4;
	localparam int CLC_HALF_START = 12;
	localparam int CLC_CLK_MHZ = 40;

	// ----------------------------------------------------------------
	// cell configuration
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CLC_NORMAL = 2'b00,
		CLC_ARITH = 2'b01,
		CLC_COUNTER = 2'b10
	} clc_mode_t;

	typedef enum logic [1:0] {
		CLC_FF_D = 2'b00,
		CLC_FF_T = 2'b01,
		CLC_FF_JK = 2'b10,
		CLC_FF_SR = 2'b11
	} clc_ff_t;

	// lut[31:16] mode[15:14] ff[13:12] carry_sel[11] casc_en[10]
	// casc_or[9] bypass[8] fb_carry[7] ce_en[6] spare[5:0]
	typedef struct packed {
		logic [15:0] lut;
		clc_mode_t mode;
		clc_ff_t ff;
		logic carry_sel;
		logic casc_en;
		logic casc_or;
		logic bypass;
		logic fb_carry;
		logic ce_en;
		logic [5:0] spare;
	} clc_cell_cfg_t;

	localparam logic [31:0] CLC_CFG_RST = 32'h0000_0000;

	typedef struct packed {
		logic clk_en;
		logic aclr_n;
		logic sclr;
		logic sload;
	} clc_ctl_t;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] CLC_CFG0_ADDR = 8'h00;
	localparam logic [7:0] CLC_CTRL_ADDR = 8'h28;
	localparam logic [7:0] CLC_STAT_ADDR = 8'h2c;
	localparam int CLC_CTRL_W = 3;
	localparam int CLC_CTRL_LOCAL = 0;
	localparam int CLC_CTRL_DCLR_EN = 1;
	localparam int CLC_CTRL_RUN = 2;
	localparam logic [2:0] CLC_CTRL_RST = 3'h0;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} clc_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} clc_apb_rsp_t;

endpackage : clc_pkg

`default_nettype wire

// File: rtl/clc_logic_cell.sv
/*
 * One logic cell: four-input lookup table, programmable flipflop, carry and
 * cascade stages, three operating modes.
 * Assumes its configuration is static while the cluster runs and that the
 * cluster supplies shared control lines in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module clc_logic_cell #(
	parameter bit FB_CAPABLE = 1'b0
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// configuration and cluster controls
	input wire clc_pkg::clc_cell_cfg_t cfg_i,
	input wire clc_pkg::clc_ctl_t ctl_i,
	// data and chain inputs
	input wire logic [3:0] data_i,
	input wire logic carry_in_i,
	input wire logic casc_in_i,
	// outputs
	output logic local_o,
	output logic global_o,
	output logic carry_o,
	output logic casc_o
);
	import clc_pkg::*;

	typedef struct packed {
		logic ff;
	} clc_cell_st_t;

	clc_cell_st_t s_q;
	clc_cell_st_t s_d;
	logic cin;
	logic lut_o;
	logic comb;
	logic nxt;
	logic ce;

	always_comb begin
		s_d = s_q;
		cin = (FB_CAPABLE && cfg_i.fb_carry) ? s_q.ff : carry_in_i;
		lut_o = 1'b0;
		carry_o = 1'b0;
		ce = ctl_i.clk_en;
		case (cfg_i.mode)
			CLC_NORMAL: begin
				// extra top cell of an adder takes carry in here
				lut_o = cfg_i.lut[{data_i[3], cfg_i.carry_sel ? cin : data_i[2],
					data_i[1], data_i[0]}];
			end
			CLC_ARITH: begin
				lut_o = cfg_i.lut[{1'b0, cin, data_i[1], data_i[0]}];
				carry_o = cfg_i.lut[{1'b1, cin, data_i[1], data_i[0]}];
			end
			CLC_COUNTER: begin
				lut_o = cfg_i.lut[{1'b0, cin, data_i[1], s_q.ff}];
				carry_o = cfg_i.lut[{1'b1, cin, data_i[1], s_q.ff}];
				if (!FB_CAPABLE && cfg_i.ce_en) begin
					ce = ctl_i.clk_en & data_i[0];
				end
			end
			default: begin
				lut_o = 1'b0;
			end
		endcase
		// or-type is the inverted and-gate, equivalent at this level
		if (cfg_i.casc_en) begin
			comb = cfg_i.casc_or ? (lut_o | casc_in_i) : (lut_o & casc_in_i);
		end else begin
			comb = lut_o;
		end
		casc_o = comb;
		case (cfg_i.ff)
			CLC_FF_D: nxt = comb;
			CLC_FF_T: nxt = s_q.ff ^ comb;
			CLC_FF_JK: nxt = (comb & ~s_q.ff) | (~data_i[3] & s_q.ff);
			CLC_FF_SR: nxt = comb | (~data_i[3] & s_q.ff);
			default: nxt = comb;
		endcase
		if (!ctl_i.aclr_n) begin
			s_d.ff = 1'b0;
		end else if (ce) begin
			if (ctl_i.sclr) begin
				s_d.ff = 1'b0;
			end else if (ctl_i.sload) begin
				s_d.ff = data_i[2];
			end else begin
				s_d.ff = nxt;
			end
		end
		// an or-type cascade cannot hand its result through the register
		local_o = (cfg_i.bypass || cfg_i.casc_or) ? comb : s_q.ff;
		global_o = local_o;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_clear_beats_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		ctl_i.aclr_n && ce && ctl_i.sclr && ctl_i.sload |=> !s_q.ff)
		else $error("sync clear lost to sync load");
	a_load_takes_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		ctl_i.aclr_n && ce && !ctl_i.sclr && ctl_i.sload |=> s_q.ff == $past(data_i[2]))
		else $error("sync load value wrong");
	a_bypass_output: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		cfg_i.bypass |-> (local_o == comb) && (global_o == comb))
		else $error("bypassed cell not combinational");
	a_or_no_register: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		cfg_i.casc_en && cfg_i.casc_or |-> local_o == (lut_o | casc_in_i))
		else $error("or cascade used register");

endmodule : clc_logic_cell

`default_nettype wire

// File: rtl/clc_cell_cluster.sv
/*
 * Cell cluster: ten logic cells, their carry and cascade chain links,
 * shared control lines and an APB register file holding every cell's
 * configuration.
 * Assumes the APB master, the general routing and neighbouring clusters all
 * run on clk_sys_i; only the device-wide clear arrives from a pin.
 */
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module clc_cell_cluster #(
	parameter int CLUSTER_POS = 1,
	parameter int HALF_START = clc_pkg::CLC_HALF_START
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// register bus
	input wire clc_pkg::clc_apb_req_t apb_req_i,
	output var clc_pkg::clc_apb_rsp_t apb_rsp_o,
	// global control lines
	input wire logic glb_clk_en_i,
	input wire logic glb_aclr_n_i,
	input wire logic device_wide_clear_n_i,
	// cell inputs from local interconnect
	input wire logic [clc_pkg::CLC_NCELL-1:0][3:0] cell_data_i,
	// chain links from the cluster two places lower
	input wire logic carry_in_i,
	input wire logic casc_in_i,
	// chain links toward the cluster two places higher
	output logic carry_out_o,
	output logic casc_out_o,
	// cell outputs
	output logic [clc_pkg::CLC_NCELL-1:0] local_out_o,
	output logic [clc_pkg::CLC_NCELL-1:0] global_out_o
);
	import clc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		clc_cell_cfg_t [CLC_NCELL-1:0] cfg;
		logic [CLC_CTRL_W-1:0] ctrl;
		logic [31:0] prdata;
		logic pslverr;
		logic [1:0] dclr_sync;
	} clc_clu_st_t;

	clc_clu_st_t s_q;
	clc_clu_st_t s_d;
	logic [1:0] rst_sync_q;
	logic rst_n;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic addr_ok(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= CLC_STAT_ADDR);
	endfunction : addr_ok

	function automatic logic is_cfg(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a < CLC_CTRL_ADDR);
	endfunction : is_cfg

	// identity of the chain operator, so a cut chain is transparent
	function automatic logic casc_neutral(input clc_cell_cfg_t c);
		return !c.casc_or;
	endfunction : casc_neutral

	// clusters with no same-parity predecessor in their row half
	// start a fresh chain; the row wiring itself skips one cluster
	localparam bit CHAIN_HEAD = (CLUSTER_POS <= 2) ||
		(CLUSTER_POS == HALF_START) || (CLUSTER_POS == HALF_START + 1);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// cells and chain wiring
	// ----------------------------------------------------------------
	logic [CLC_NCELL-1:0] loc;
	logic [CLC_NCELL-1:0] glb;
	logic [CLC_NCELL-1:0] cry;
	logic [CLC_NCELL-1:0] csc;
	logic [CLC_NCELL-1:0] cin_w;
	logic [CLC_NCELL-1:0] csin_w;
	clc_cell_cfg_t [CLC_NCELL-1:0] cfg_eff;
	clc_ctl_t ctl;
	logic dclr_act;
	logic wr_fire;
	logic run;

	always_comb begin
		cfg_eff = s_q.cfg;
		cfg_eff[0].casc_en = 1'b0;
		cin_w = '0;
		csin_w = '0;
		cin_w[0] = 1'b0;
		csin_w[0] = 1'b1;
		if (CHAIN_HEAD) begin
			cin_w[1] = 1'b0;
			csin_w[1] = casc_neutral(s_q.cfg[1]);
		end else begin
			cin_w[1] = carry_in_i;
			csin_w[1] = casc_in_i;
		end
		for (int i = 2; i < CLC_NCELL; i++) begin
			cin_w[i] = cry[i-1];
			csin_w[i] = csc[i-1];
		end
	end

	for (genvar g = 0; g < CLC_NCELL; g++) begin : g_cell
		clc_logic_cell #(
			.FB_CAPABLE(g == 1)
		) u_cell (
			.clk_sys_i(clk_sys_i),
			.rst_n_i(rst_n),
			.cfg_i(cfg_eff[g]),
			.ctl_i(ctl),
			.data_i(cell_data_i[g]),
			.carry_in_i(cin_w[g]),
			.casc_in_i(csin_w[g]),
			.local_o(loc[g]),
			.global_o(glb[g]),
			.carry_o(cry[g]),
			.casc_o(csc[g])
		);
	end

	// top carry goes to the next chain; an adder's final carry is
	// instead read by a normal-mode cell with carry_sel set
	assign carry_out_o = cry[CLC_NCELL-1];
	assign casc_out_o = csc[CLC_NCELL-1];
	assign local_out_o = loc;
	assign global_out_o = glb;

	// ----------------------------------------------------------------
	// cluster control lines
	// ----------------------------------------------------------------
	assign dclr_act = s_q.ctrl[CLC_CTRL_DCLR_EN] && !s_q.dclr_sync[1];

	always_comb begin
		if (s_q.ctrl[CLC_CTRL_LOCAL]) begin
			ctl.clk_en = cell_data_i[0][0];
			ctl.aclr_n = cell_data_i[0][1];
			ctl.sclr = cell_data_i[0][2];
			ctl.sload = cell_data_i[0][3];
		end else begin
			ctl.clk_en = glb_clk_en_i;
			ctl.aclr_n = glb_aclr_n_i;
			ctl.sclr = 1'b0;
			ctl.sload = 1'b0;
		end
		if (dclr_act) begin
			ctl.aclr_n = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	assign run = s_q.ctrl[CLC_CTRL_RUN];
	assign wr_fire = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;

	always_comb begin
		s_d = s_q;
		s_d.dclr_sync = {s_q.dclr_sync[0], device_wide_clear_n_i};
		// read data is taken in the setup phase so it comes from flops
		if (apb_req_i.psel && !apb_req_i.penable) begin
			s_d.pslverr = !addr_ok(apb_req_i.paddr);
			if (is_cfg(apb_req_i.paddr)) begin
				s_d.prdata = s_q.cfg[apb_req_i.paddr[7:2]];
			end else if (apb_req_i.paddr == CLC_CTRL_ADDR) begin
				s_d.prdata = 32'(s_q.ctrl);
			end else if (apb_req_i.paddr == CLC_STAT_ADDR) begin
				s_d.prdata = 32'({csc[CLC_NCELL-1], cry[CLC_NCELL-1], loc});
			end else begin
				s_d.prdata = 32'h0000_0000;
			end
		end
		if (wr_fire && !s_q.pslverr) begin
			if (apb_req_i.paddr == CLC_CTRL_ADDR) begin
				s_d.ctrl = apb_req_i.pwdata[CLC_CTRL_W-1:0];
			end else if (is_cfg(apb_req_i.paddr) && !run) begin
				s_d.cfg[apb_req_i.paddr[7:2]] = apb_req_i.pwdata;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			s_q.cfg <= {CLC_NCELL{CLC_CFG_RST}};
			s_q.ctrl <= CLC_CTRL_RST;
			s_q.prdata <= 32'h0000_0000;
			s_q.pslverr <= 1'b0;
			s_q.dclr_sync <= 2'b11;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		apb_rsp_o.pready = 1'b1;
		apb_rsp_o.pslverr = apb_req_i.psel && apb_req_i.penable && s_q.pslverr;
		apb_rsp_o.prdata = s_q.prdata;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking

	default disable iff (!rst_n);

	a_bus_unmapped: assert property (
		apb_req_i.psel && !apb_req_i.penable && !addr_ok(apb_req_i.paddr)
		##1 apb_req_i.psel && apb_req_i.penable |-> apb_rsp_o.pslverr)
		else $error("unmapped access not flagged");
	a_cfg_frozen: assert property (
		wr_fire && run && is_cfg(apb_req_i.paddr) |=> $stable(s_q.cfg))
		else $error("configuration changed while running");
	a_local_ctl: assert property (
		s_q.ctrl[CLC_CTRL_LOCAL] |-> ctl.sclr == cell_data_i[0][2] &&
		ctl.sload == cell_data_i[0][3] && ctl.clk_en == cell_data_i[0][0])
		else $error("first cell not driving controls");
	a_first_excluded: assert property (
		!cin_w[0] && !cfg_eff[0].casc_en && (cin_w[2] == cry[1]))
		else $error("first cell joined a chain");
	a_chain_link: assert property (
		cin_w[CLC_NCELL-1:2] == cry[CLC_NCELL-2:1] &&
		csin_w[CLC_NCELL-1:2] == csc[CLC_NCELL-2:1])
		else $error("chain link broken");
	a_chain_head: assert property (
		CHAIN_HEAD |-> !cin_w[1])
		else $error("chain crossed its start");
	a_dev_clear: assert property (
		s_q.ctrl[CLC_CTRL_DCLR_EN] throughout (!device_wide_clear_n_i [*3])
		|-> !ctl.aclr_n)
		else $error("device clear did not override");

endmodule : clc_cell_cluster

`default_nettype wire

// File: dv/clc_nbr_model.sv
/*
 * Model of the neighbouring cluster two places lower in the row: it drives
 * the carry and cascade links into the cluster under test.
 * Assumes the bench sets its levels through the drive task only.
 */
`timescale 1ns/1ps
`default_nettype none

module clc_nbr_model (
	// clock
	input wire logic clk_sys_i,
	// chain links toward the cluster under test
	output logic carry_o,
	output logic casc_o
);
	logic [1:0] lvl_q = 2'h0;

	// levels move only after a rising edge, as from an upstream flop
	task automatic drive(input logic [1:0] v);
		@(posedge clk_sys_i);
		lvl_q <= v;
	endtask : drive

	assign carry_o = lvl_q[0];
	assign casc_o = lvl_q[1];
endmodule : clc_nbr_model

`default_nettype wire

// File: dv/clc_cell_cluster_tb_top.sv
/*
 * Self-checking bench for the cell cluster: APB tasks, then tests of
 * reset values, lookup table, chains and shared flipflop controls.
 * Assumes zero or more wait states on APB and one 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module clc_cell_cluster_tb_top;
	import clc_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	clc_apb_req_t req = '0;
	clc_apb_rsp_t rsp;
	logic glb_aclr_n = 1'b1;
	logic dev_clr_n = 1'b1;
	logic [CLC_NCELL-1:0][3:0] cdata = '0;
	logic cin;
	logic kin;
	logic cout;
	logic kout;
	logic [CLC_NCELL-1:0] lo;
	logic [CLC_NCELL-1:0] go;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic er;
	clc_cell_cfg_t c;
	localparam logic [15:0] LUT_T = 16'h8e31;

	initial forever #12.5 clk_sys_i = ~clk_sys_i;

	clc_nbr_model nbr (.clk_sys_i(clk_sys_i), .carry_o(cin), .casc_o(kin));

	clc_cell_cluster #(.CLUSTER_POS(3), .HALF_START(CLC_HALF_START)) dut (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .apb_req_i(req), .apb_rsp_o(rsp),
		.glb_clk_en_i(1'b1), .glb_aclr_n_i(glb_aclr_n), .device_wide_clear_n_i(dev_clr_n),
		.cell_data_i(cdata), .carry_in_i(cin), .casc_in_i(kin),
		.carry_out_o(cout), .casc_out_o(kout), .local_out_o(lo), .global_out_o(go)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	// a hang counts as a mismatch
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_sys_i);
		req.penable <= 1'b1;
		@(posedge clk_sys_i);
		while (rsp.pready !== 1'b1) @(posedge clk_sys_i);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask : apb

	task automatic cfg(input int n, input logic [15:0] l, input clc_mode_t m,
			input logic byp, input logic ke, input logic kor);
		c = '0;
		c.lut = l;
		c.mode = m;
		c.ff = CLC_FF_D;
		c.bypass = byp;
		c.casc_en = ke;
		c.casc_or = kor;
		apb(1'b1, CLC_CFG0_ADDR + 8'(4 * n), c);
	endtask : cfg

	// cell0 inputs: bit0 enable, bit1 clear_n, bit2 sync clear, bit3 load
	// outputs read at an edge show the state of the edge before, so wait
	// one edge beyond the two-flop pin sync plus the flop update
	task automatic flops(input logic [3:0] ctl, input logic [1:0] e);
		cdata[0] <= ctl;
		repeat (4) @(posedge clk_sys_i);
		chk("cells 5,4", 32'(lo[5:4]), 32'(e));
	endtask : flops

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		apb(1'b0, CLC_CFG0_ADDR + 8'h24, 32'h0);
		chk("cfg9 reset", rd, CLC_CFG_RST);
		apb(1'b0, CLC_CTRL_ADDR, 32'h0);
		chk("ctrl reset", rd, 32'(CLC_CTRL_RST));
		apb(1'b1, 8'h30, 32'hffff_ffff);
		chk("unmapped err", 32'(er), 32'h1);
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped data", rd, 32'h0);
		chk("outs reset", 32'(lo), 32'h0);
		$display("test reset done");

		cfg(3, LUT_T, CLC_NORMAL, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 16; i++) begin
			cdata[3] <= 4'(i);
			@(posedge clk_sys_i);
			chk("lut local", 32'(lo[3]), 32'(LUT_T[i]));
			chk("lut global", 32'(go[3]), 32'(LUT_T[i]));
		end
		$display("test lut done");

		// each of cells 1 to 9 passes carry through as sum and carry
		for (int k = 0; k < 2; k++) begin
			for (int n = 1; n < CLC_NCELL; n++) cfg(n, 16'hf0f0, CLC_ARITH, 1'b1, 1'b1, 1'(k));
			for (int v = 0; v < 4; v++) begin
				nbr.drive(2'(v));
				@(posedge clk_sys_i);
				chk("carry out", 32'(cout), 32'(v & 1));
				chk("casc out", 32'(kout), 32'(k ? (v != 0) : (v == 3)));
			end
		end
		$display("test chains done");

		cfg(4, 16'haaaa, CLC_NORMAL, 1'b0, 1'b0, 1'b0);
		cfg(5, 16'haaaa, CLC_NORMAL, 1'b0, 1'b0, 1'b0);
		cdata[4] <= 4'h1;
		cdata[5] <= 4'h5;
		flops(4'h0, 2'b11);
		glb_aclr_n <= 1'b0;
		flops(4'h0, 2'b00);
		glb_aclr_n <= 1'b1;
		apb(1'b1, CLC_CTRL_ADDR, 32'h1);
		flops(4'h3, 2'b11);
		flops(4'hb, 2'b10);
		flops(4'hf, 2'b00);
		flops(4'h3, 2'b11);
		flops(4'h1, 2'b00);
		flops(4'h3, 2'b11);
		apb(1'b0, CLC_STAT_ADDR, 32'h0);
		chk("stat outs", 32'(rd[5:4]), 32'h3);
		apb(1'b1, CLC_CTRL_ADDR, 32'h2);
		dev_clr_n <= 1'b0;
		flops(4'h3, 2'b00);
		dev_clr_n <= 1'b1;
		flops(4'h3, 2'b11);
		$display("test flops done");

		apb(1'b1, CLC_CTRL_ADDR, 32'h4);
		apb(1'b1, CLC_CFG0_ADDR + 8'h10, 32'h0);
		apb(1'b0, CLC_CFG0_ADDR + 8'h10, 32'h0);
		chk("cfg frozen", rd, 32'haaaa_0000);
		$display("test freeze done");
		conclude();
	end
endmodule : clc_cell_cluster_tb_top

`default_nettype wire
